// ### core/sbr_pkg.sv
// shared constants, codes and state types of the serial boot responder
package sbr_pkg;

	localparam int CW = 20;

	// matching, command and reply codes
	localparam logic [7:0] MATCH1_A    = 8'h86;
	localparam logic [7:0] MATCH1_B    = 8'h30;
	localparam logic [7:0] MATCH2_A    = 8'h79;
	localparam logic [7:0] MATCH2_B    = 8'hCF;
	localparam logic [7:0] CMD_SUM     = 8'h90;
	localparam logic [7:0] CMD_ID      = 8'hC0;
	localparam logic [7:0] ERR_COMM    = 8'hA1;
	localparam logic [7:0] ERR_OVR     = 8'hA3;
	localparam logic [7:0] ERR_CMD     = 8'h63;
	localparam logic [7:0] FLAG_ERASED = 8'hAA;
	localparam logic [7:0] FLAG_DATA   = 8'h55;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;

	// writable flash range covered by the checksum
	localparam logic [15:0] FLASH_FIRST = 16'h8000;
	localparam logic [15:0] FLASH_LAST  = 16'hFFFF;

	// identification record: start mark, count, nineteen payload bytes
	localparam int ID_REC_LEN = 21;
	localparam logic [7:0] ID_REC [ID_REC_LEN] = '{
		8'h3A, 8'h13, 8'h03, 8'hFD, 8'h00, 8'h00, 8'h00,
		8'h80, 8'h01, 8'h00, 8'h80, 8'h00, 8'h00, 8'hFF,
		8'hFF, 8'h00, 8'h00, 8'h60, 8'h00, 8'h08, 8'h3F};

	// byte indices inside each reply
	localparam logic [4:0] IDX_ECHO_LAST = 5'h00;
	localparam logic [4:0] IDX_SUM_LAST  = 5'h02;
	localparam logic [4:0] IDX_ERR_LAST  = 5'h02;
	localparam logic [4:0] IDX_PAY_FIRST = 5'h03;
	localparam logic [4:0] IDX_PAY_LAST  = 5'h15;
	localparam logic [4:0] IDX_ID_LAST   = 5'h16;

	// autobaud ratio bounds of 4*low-run against high-run
	localparam logic [3:0] AB_LO_A = 4'h3;
	localparam logic [3:0] AB_HI_A = 4'h5;
	localparam logic [3:0] AB_LO_B = 4'h9;
	localparam logic [3:0] AB_HI_B = 4'hB;

	// serial frame bit positions
	localparam logic [3:0] BIT_START = 4'h0;
	localparam logic [3:0] BIT_STOP  = 4'h9;

	typedef enum logic [3:0] {
		ST_HUNT   = 4'b0000,
		ST_BLOW   = 4'b0001,
		ST_BHIGH  = 4'b0011,
		ST_BTAIL  = 4'b0010,
		ST_SEND   = 4'b0110,
		ST_MATCH2 = 4'b0111,
		ST_CMD    = 4'b0101,
		ST_SUM    = 4'b0100,
		ST_IDLE   = 4'b1100
	} sbr_state_e;

	typedef enum logic [2:0] {
		K_ECHO1, K_ECHO2, K_SUM, K_ID, K_ERR
	} sbr_kind_e;

	typedef struct packed {
		logic          r_on;
		logic [CW-1:0] r_cnt;
		logic [3:0]    r_bit;
		logic [7:0]    r_sh;
		logic          r_valid;
		logic          r_ferr;
		logic          t_on;
		logic [CW-1:0] t_cnt;
		logic [3:0]    t_bit;
		logic [7:0]    t_sh;
		logic          txd;
	} sbr_uart_s;

endpackage : sbr_pkg

// ### core/sbr_uart.sv
// byte-wide serial receiver and transmitter at a programmable bit period
module sbr_uart
	import sbr_pkg::*;
(
	// clock and reset
	input  wire logic          clock_i,
	input  wire logic          rst_n_i,
	// bit period in clock cycles
	input  wire logic [CW-1:0] bit_cyc_i,
	// receive side
	input  wire logic          rx_en_i,
	input  wire logic          rxd_i,
	output logic               rx_valid_o,
	output logic [7:0]         rx_data_o,
	output logic               rx_ferr_o,
	// transmit side
	input  wire logic          tx_go_i,
	input  wire logic [7:0]    tx_data_i,
	output logic               tx_ready_o,
	output logic               txd_o
);
	import sbr_pkg::*;

	sbr_uart_s s_q, s_d;

	always_comb begin
		s_d = s_q;
		s_d.r_valid = 1'b0;
		// receiver: sample mid-bit, start bit checked again
		if (!s_q.r_on) begin
			if (rx_en_i && !rxd_i) begin
				s_d.r_on  = 1'b1;
				s_d.r_cnt = bit_cyc_i >> 1;
				s_d.r_bit = BIT_START;
			end
		end else if (s_q.r_cnt != '0) begin
			s_d.r_cnt = s_q.r_cnt - 1'b1;
		end else begin
			s_d.r_cnt = bit_cyc_i - 1'b1;
			s_d.r_bit = s_q.r_bit + 1'b1;
			if (s_q.r_bit == BIT_START) begin
				if (rxd_i)
					s_d.r_on = 1'b0;
			end else if (s_q.r_bit == BIT_STOP) begin
				s_d.r_on    = 1'b0;
				s_d.r_valid = 1'b1;
				s_d.r_ferr  = !rxd_i;
			end else begin
				s_d.r_sh = {rxd_i, s_q.r_sh[7:1]};
			end
		end
		// transmitter: start, eight data bits lsb first, stop
		if (!s_q.t_on) begin
			if (tx_go_i) begin
				s_d.t_on  = 1'b1;
				s_d.t_sh  = tx_data_i;
				s_d.txd   = 1'b0;
				s_d.t_bit = BIT_START;
				s_d.t_cnt = bit_cyc_i - 1'b1;
			end
		end else if (s_q.t_cnt != '0) begin
			s_d.t_cnt = s_q.t_cnt - 1'b1;
		end else if (s_q.t_bit == BIT_STOP) begin
			s_d.t_on = 1'b0;
		end else begin
			s_d.txd   = (s_q.t_bit == BIT_STOP - 1'b1) ? 1'b1 : s_q.t_sh[0];
			s_d.t_sh  = {1'b1, s_q.t_sh[7:1]};
			s_d.t_bit = s_q.t_bit + 1'b1;
			s_d.t_cnt = bit_cyc_i - 1'b1;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q     <= '0;
			s_q.txd <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign rx_valid_o = s_q.r_valid;
	assign rx_data_o  = s_q.r_sh;
	assign rx_ferr_o  = s_q.r_ferr;
	assign tx_ready_o = !s_q.t_on;
	assign txd_o      = s_q.txd;

endmodule : sbr_uart

// ### core/sbr_top.sv
// serial boot responder: autobaud, matching, checksum and id commands
// Operation
// [R1] first byte 0x86 or 0x30 sets baud rate; echo it, else stay silent
// [R2] second byte 0x79 or 0xCF is echoed, otherwise nothing is sent
// [R3] checksum command 0x90 is taken without echo; flag byte follows
// [R4] command-phase error sends one error code three times, then idle
// [R5] flag is 0xAA when all summed bytes are 0xFF, else 0x55
// [R6] checksum goes out high byte then low byte after the flag
// [R7] after the last reply byte, wait for the next command byte
// [R8] id command 0xC0 is echoed before the record
// [R9] record opens with 0x3A and payload count 0x13
// [R10] payload: address length 3, then 0xFD and three zero bytes
// [R11] then size code 0x80 and block count 0x01
// [R12] flash range 0x008000 to 0x00FFFF, most significant byte first
// [R13] loader RAM range 0x000060 to 0x00083F, most significant first
// [R14] last byte is two's complement of the payload byte sum
// [R15] after idle the controller must reset the device to resume
// [R16] checksum is the 16-bit sum of all flash range bytes
module sbr_top
	import sbr_pkg::*;
(
	// clock and reset
	input  wire logic        clock_i,
	input  wire logic        rst_n_i,
	// serial link
	input  wire logic        rxd_i,
	output logic             txd_o,
	// flash read port, data one cycle after the strobe
	output logic [15:0]      flash_addr_o,
	output logic             flash_rd_o,
	input  wire logic [7:0]  flash_data_i,
	// status
	output logic             idle_o
);
	import sbr_pkg::*;

	typedef struct packed {
		sbr_state_e    st;
		sbr_kind_e     kind;
		logic [4:0]    idx;
		logic [CW-1:0] cnt_lo;
		logic [CW-1:0] cnt_hi;
		logic [CW-1:0] tail;
		logic [CW-1:0] bit_cyc;
		logic [7:0]    echo_b;
		logic [7:0]    err_b;
		logic          go;
		logic [7:0]    tx_b;
		logic [15:0]   addr;
		logic          rd;
		logic          rv;
		logic          rlast;
		logic [15:0]   sum;
		logic          all_ff;
		logic [7:0]    ck;
		logic          idle;
	} sbr_top_s;

	sbr_top_s s_q, s_d;

	logic       rx_valid;
	logic [7:0] rx_data;
	logic       rx_ferr;
	logic       tx_ready;
	logic       rx_en;

	assign rx_en = (s_q.st == ST_MATCH2) || (s_q.st == ST_CMD);

	sbr_uart u_uart (
		.clock_i    (clock_i),
		.rst_n_i    (rst_n_i),
		.bit_cyc_i  (s_q.bit_cyc),
		.rx_en_i    (rx_en),
		.rxd_i      (rxd_i),
		.rx_valid_o (rx_valid),
		.rx_data_o  (rx_data),
		.rx_ferr_o  (rx_ferr),
		.tx_go_i    (s_q.go),
		.tx_data_i  (s_q.tx_b),
		.tx_ready_o (tx_ready),
		.txd_o      (txd_o)
	);

	////////////////////////////////////////////////////////////////////////
	// reply byte selection

	function automatic logic [7:0] reply_byte(input sbr_top_s s);
		logic [7:0] b;
		b = s.echo_b;
		unique case (s.kind)
			K_ECHO1, K_ECHO2: b = s.echo_b;
			K_SUM: begin
				if (s.idx == IDX_ECHO_LAST)
					b = s.all_ff ? FLAG_ERASED : FLAG_DATA; // R5
				else if (s.idx == IDX_SUM_LAST)
					b = s.sum[7:0]; // R6
				else
					b = s.sum[15:8]; // R6
			end
			K_ID: begin
				if (s.idx == IDX_ECHO_LAST)
					b = CMD_ID; // R8
				else if (s.idx == IDX_ID_LAST)
					b = 8'(~s.ck + 1'b1); // R14
				else
					b = ID_REC[s.idx - 1'b1]; // R9 R10 R11 R12 R13
			end
			K_ERR: b = s.err_b; // R4
		endcase
		return b;
	endfunction : reply_byte

	function automatic logic [4:0] last_idx(input sbr_kind_e k);
		logic [4:0] l;
		l = IDX_ECHO_LAST;
		unique case (k)
			K_ECHO1, K_ECHO2: l = IDX_ECHO_LAST;
			K_SUM:            l = IDX_SUM_LAST;
			K_ID:             l = IDX_ID_LAST;
			K_ERR:            l = IDX_ERR_LAST; // R4
		endcase
		return l;
	endfunction : last_idx

	////////////////////////////////////////////////////////////////////////
	// sequencer

	always_comb begin
		logic [CW+3:0] lo4;
		logic [CW+3:0] hi_w;
		logic [7:0]    b;
		lo4  = (CW+4)'({s_q.cnt_lo, 2'b00});
		hi_w = (CW+4)'(s_q.cnt_hi);
		b    = reply_byte(s_q);
		s_d    = s_q;
		s_d.go = 1'b0;
		s_d.rv = 1'b0;
		unique case (s_q.st)
			ST_HUNT: begin
				if (!rxd_i) begin
					s_d.cnt_lo = CW'(1);
					s_d.st     = ST_BLOW;
				end
			end
			// first low run: start bit plus leading zero bits
			ST_BLOW: begin
				if (rxd_i) begin
					s_d.cnt_hi = CW'(1);
					s_d.st     = ST_BHIGH;
				end else if (~&s_q.cnt_lo) begin
					s_d.cnt_lo = s_q.cnt_lo + 1'b1;
				end
			end
			// first high run is two bit times for both legal bytes
			ST_BHIGH: begin
				if (!rxd_i) begin
					s_d.tail = '0;
					s_d.st   = ST_BTAIL;
				end else if (~&s_q.cnt_hi) begin
					s_d.cnt_hi = s_q.cnt_hi + 1'b1;
				end
			end
			// wait for two idle bit times, then classify the byte
			ST_BTAIL: begin
				s_d.tail = rxd_i ? s_q.tail + 1'b1 : '0;
				if (rxd_i && s_q.tail >= s_q.cnt_hi) begin
					s_d.bit_cyc = s_q.cnt_hi >> 1; // R1
					s_d.kind    = K_ECHO1;
					s_d.idx     = '0;
					s_d.st      = ST_SEND;
					if (lo4 >= hi_w * AB_LO_A && lo4 <= hi_w * AB_HI_A)
						s_d.echo_b = MATCH1_A; // R1
					else if (lo4 >= hi_w * AB_LO_B && lo4 <= hi_w * AB_HI_B)
						s_d.echo_b = MATCH1_B; // R1
					else
						s_d.st = ST_HUNT; // R1
				end
			end
			ST_MATCH2: begin
				if (rx_valid) begin
					s_d.idx    = '0;
					s_d.echo_b = rx_data;
					s_d.kind   = K_ECHO2;
					if (!rx_ferr && (rx_data == MATCH2_A ||
							rx_data == MATCH2_B))
						s_d.st = ST_SEND; // R2
					else
						s_d.st = ST_IDLE; // R2
				end
			end
			ST_CMD: begin
				if (rx_valid) begin
					s_d.idx = '0;
					s_d.ck  = '0;
					if (rx_ferr || !tx_ready) begin
						s_d.err_b = rx_ferr ? ERR_COMM : ERR_OVR; // R4
						s_d.kind  = K_ERR;
						s_d.st    = ST_SEND;
					end else if (rx_data == CMD_SUM) begin
						s_d.st     = ST_SUM; // R3
						s_d.kind   = K_SUM;
						s_d.rd     = 1'b1;
						s_d.addr   = FLASH_FIRST;
						s_d.sum    = '0;
						s_d.all_ff = 1'b1;
					end else if (rx_data == CMD_ID) begin
						s_d.kind = K_ID; // R8
						s_d.st   = ST_SEND;
					end else begin
						s_d.err_b = ERR_CMD; // R4
						s_d.kind  = K_ERR;
						s_d.st    = ST_SEND;
					end
				end
			end
			// pipelined pass over the flash range
			ST_SUM: begin
				if (s_q.rd) begin
					s_d.rv    = 1'b1;
					s_d.rlast = (s_q.addr == FLASH_LAST);
					if (s_q.addr == FLASH_LAST) begin
						s_d.rd   = 1'b0;
					end else begin
						s_d.addr = s_q.addr + 1'b1;
					end
				end
				if (s_q.rv) begin
					s_d.sum = s_q.sum + 16'(flash_data_i); // R16
					if (flash_data_i != ERASED_BYTE)
						s_d.all_ff = 1'b0; // R5
					if (s_q.rlast)
						s_d.st = ST_SEND; // R3
				end
			end
			ST_SEND: begin
				if (tx_ready && !s_q.go) begin
					s_d.go   = 1'b1;
					s_d.tx_b = b;
					if (s_q.kind == K_ID && s_q.idx >= IDX_PAY_FIRST &&
							s_q.idx <= IDX_PAY_LAST)
						s_d.ck = s_q.ck + b; // R14
					if (s_q.idx == last_idx(s_q.kind)) begin
						unique case (s_q.kind)
							K_ECHO1: s_d.st = ST_MATCH2;
							K_ECHO2, K_SUM, K_ID: s_d.st = ST_CMD; // R7
							K_ERR: s_d.st = ST_IDLE; // R4
						endcase
					end else begin
						s_d.idx = s_q.idx + 1'b1;
					end
				end
			end
			// silent until reset
			// flag rises only once any pending reply byte, such as the third error byte, has left the line
			ST_IDLE: begin
				if (tx_ready && !s_q.go)
					s_d.idle = 1'b1; // R4
			end
			default: s_d.st = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q      <= '0;
			s_q.st   <= ST_HUNT;
			s_q.kind <= K_ECHO1;
		end else begin
			s_q <= s_d;
		end
	end

	assign flash_addr_o = s_q.addr;
	assign flash_rd_o   = s_q.rd;
	assign idle_o       = s_q.idle;

endmodule : sbr_top

// ### verif/sbr_top_asserts.sv
// concurrent checks on the serial boot responder ports
module sbr_top_asserts
	import sbr_pkg::*;
(
	// watched ports
	input  wire logic        clock_i,
	input  wire logic        rst_n_i,
	input  wire logic        rxd_i,
	input  wire logic        txd_o,
	input  wire logic [15:0] flash_addr_o,
	input  wire logic        flash_rd_o,
	input  wire logic [7:0]  flash_data_i,
	input  wire logic        idle_o
);
	// length of the current flash read run
	logic [16:0] run_q;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			run_q <= '0;
		end else begin
			run_q <= flash_rd_o ? run_q + 17'h1 : '0;
		end
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	bit_len_a: assert property ($fell(txd_o) |-> (!txd_o) [*8])
		else $error("low run shorter than one bit");
	idle_sticky_a: assert property (idle_o |=> idle_o)
		else $error("idle flag dropped");
	idle_quiet_a: assert property (idle_o |-> txd_o && !flash_rd_o)
		else $error("activity while idle");
	no_echo_a: assert property (flash_rd_o |-> txd_o)
		else $error("transmit during scan");
	flag_next_a: assert property ($fell(flash_rd_o) |-> ##[1:20] $fell(txd_o))
		else $error("flag byte late");
	scan_first_a: assert property ($rose(flash_rd_o) |->
		flash_addr_o == FLASH_FIRST) else $error("scan start wrong");
	scan_step_a: assert property (flash_rd_o && $past(flash_rd_o) |->
		flash_addr_o == $past(flash_addr_o) + 16'h0001)
		else $error("scan address skipped");
	scan_last_a: assert property ($fell(flash_rd_o) |->
		$past(flash_addr_o) == FLASH_LAST) else $error("scan end wrong");
	scan_len_a: assert property ($fell(flash_rd_o) |->
		run_q == 17'h1_0000 >> 1) else $error("scan length wrong");

	scan_c: cover property ($fell(flash_rd_o));
	idle_c: cover property ($rose(idle_o));
	tx_c: cover property ($fell(txd_o));
endmodule : sbr_top_asserts

// ### verif/sbr_ctrl_model.sv
// serial programming controller model on the boot link
module sbr_ctrl_model #(
	parameter int BIT = 8
) (
	// clock
	input  wire logic clock_i,
	// link
	input  wire logic txd_i,
	output logic      rxd_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial rxd_o = 1'b1;

	// one 8N1 frame after an idle gap, every bit BIT cycles
	task automatic send(input logic [7:0] b, input int gap,
		input logic stop_ok);
		repeat (gap) @(posedge clock_i);
		rxd_o <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge clock_i);
			rxd_o <= b[i];
		end
		repeat (BIT) @(posedge clock_i);
		rxd_o <= stop_ok;
		repeat (BIT) @(posedge clock_i);
		rxd_o <= 1'b1;
	endtask : send

	// returns in mid stop bit so a following frame is not missed
	task automatic recv(output logic [7:0] b, output logic ok,
		input int lim);
		int n;
		ok = 1'b0;
		b = 8'h00;
		n = 0;
		while (txd_i !== 1'b0 && n < lim) begin
			@(posedge clock_i);
			n++;
		end
		if (n < lim) begin
			repeat (BIT / 2) @(posedge clock_i);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT) @(posedge clock_i);
				b[i] = txd_i;
			end
			repeat (BIT) @(posedge clock_i);
			ok = (txd_i === 1'b1);
		end
	endtask : recv
endmodule : sbr_ctrl_model

// ### verif/tb_top.sv
// self-checking bench for the serial boot responder
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import sbr_pkg::*;

	localparam int BIT = 8;
	logic        clock_i;
	logic        rst_n_i;
	logic        rxd;
	logic        txd;
	logic        flash_rd;
	logic        idle;
	logic        pat;
	logic [15:0] flash_addr;
	logic [7:0]  flash_data;
	int          miscompares;
	int          checked;
	int          cycles;
	logic [7:0]  id_exp [21] = '{8'h3A, 8'h13, 8'h03, 8'hFD, 8'h00,
		8'h00, 8'h00, 8'h80, 8'h01, 8'h00, 8'h80, 8'h00, 8'h00, 8'hFF,
		8'hFF, 8'h00, 8'h00, 8'h60, 8'h00, 8'h08, 8'h3F};

	sbr_top i_sbr_top (.clock_i(clock_i), .rst_n_i(rst_n_i), .rxd_i(rxd),
		.txd_o(txd), .flash_addr_o(flash_addr), .flash_rd_o(flash_rd),
		.flash_data_i(flash_data), .idle_o(idle));
	sbr_ctrl_model #(.BIT(BIT)) i_sbr_ctrl_model (.clock_i(clock_i),
		.txd_i(txd), .rxd_o(rxd));

	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end

	// flash: erased or low address byte; garbage when not read
	always @(posedge clock_i)
		flash_data <= flash_rd ? (pat ? flash_addr[7:0] : 8'hFF) : ~flash_data;

	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			miscompares++;
			test_done();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t byte %h want %h", $time, got, exp);
		end
	endtask : chk8

	task automatic chk1(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t flag %b want %b", $time, got, exp);
		end
	endtask : chk1

	task automatic do_reset(input logic p);
		@(posedge clock_i);
		rst_n_i <= 1'b0;
		pat <= p;
		repeat (20) @(posedge clock_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clock_i);
	endtask : do_reset

	task automatic rx_chk(input logic [7:0] exp);
		logic [7:0] b;
		logic       ok;
		i_sbr_ctrl_model.recv(b, ok, 100);
		chk1(ok, 1'b1);
		chk8(b, exp);
	endtask : rx_chk

	// send one byte and judge the first reply byte, or its absence
	task automatic xfer(input logic [7:0] b, input logic stop_ok,
		input logic [7:0] exp, input logic exp_ok, input int lim);
		logic [7:0] g;
		logic       ok;
		fork
			i_sbr_ctrl_model.send(b, 6 * BIT, stop_ok);
			i_sbr_ctrl_model.recv(g, ok, lim);
		join
		chk1(ok, exp_ok);
		if (exp_ok)
			chk8(g, exp);
	endtask : xfer

	task automatic end_test(input string name);
		$display("test %s ended, %0d bad so far", name, miscompares);
	endtask : end_test

	////////////////////////////////////////////////////////////////////////
	task automatic t_sum_erased;
		do_reset(1'b0);
		xfer(MATCH1_A, 1'b1, MATCH1_A, 1'b1, 400);
		xfer(MATCH2_A, 1'b1, MATCH2_A, 1'b1, 400);
		xfer(CMD_SUM, 1'b1, FLAG_ERASED, 1'b1, 40000);
		rx_chk(8'h80);
		rx_chk(8'h00);
		end_test("sum_erased");
	endtask : t_sum_erased

	task automatic t_id;
		logic [7:0] s;
		s = 8'h00;
		xfer(CMD_ID, 1'b1, CMD_ID, 1'b1, 400);
		for (int i = 0; i < 21; i++) begin
			rx_chk(id_exp[i]);
			if (i > 1)
				s = s + id_exp[i];
		end
		rx_chk(8'h00 - s);
		end_test("id");
	endtask : t_id

	task automatic t_bad_cmd;
		xfer(8'h12, 1'b1, ERR_CMD, 1'b1, 400);
		rx_chk(ERR_CMD);
		rx_chk(ERR_CMD);
		repeat (3 * BIT) @(posedge clock_i);
		chk1(idle, 1'b1);
		xfer(CMD_ID, 1'b1, 8'h00, 1'b0, 400);
		end_test("bad_cmd");
	endtask : t_bad_cmd

	task automatic t_sum_pattern;
		do_reset(1'b1);
		xfer(MATCH1_B, 1'b1, MATCH1_B, 1'b1, 400);
		xfer(MATCH2_B, 1'b1, MATCH2_B, 1'b1, 400);
		xfer(CMD_SUM, 1'b1, FLAG_DATA, 1'b1, 40000);
		rx_chk(8'hC0);
		rx_chk(8'h00);
		end_test("sum_pattern");
	endtask : t_sum_pattern

	task automatic t_frame_err;
		xfer(CMD_ID, 1'b0, ERR_COMM, 1'b1, 400);
		rx_chk(ERR_COMM);
		rx_chk(ERR_COMM);
		repeat (3 * BIT) @(posedge clock_i);
		chk1(idle, 1'b1);
		end_test("frame_err");
	endtask : t_frame_err

	task automatic t_bad_match;
		do_reset(1'b0);
		xfer(8'h0F, 1'b1, 8'h00, 1'b0, 300);
		chk1(idle, 1'b0);
		xfer(MATCH1_A, 1'b1, MATCH1_A, 1'b1, 400);
		xfer(8'h12, 1'b1, 8'h00, 1'b0, 300);
		chk1(idle, 1'b1);
		end_test("bad_match");
	endtask : t_bad_match

	// command byte lands while the second echo is still being sent
	task automatic t_overrun;
		logic [7:0] g;
		logic       ok;
		do_reset(1'b0);
		xfer(MATCH1_A, 1'b1, MATCH1_A, 1'b1, 400);
		fork
			begin
				i_sbr_ctrl_model.send(MATCH2_A, 6 * BIT, 1'b1);
				i_sbr_ctrl_model.send(CMD_ID, 1, 1'b1);
			end
			i_sbr_ctrl_model.recv(g, ok, 400);
		join
		chk1(ok, 1'b1);
		chk8(g, MATCH2_A);
		rx_chk(ERR_OVR);
		rx_chk(ERR_OVR);
		rx_chk(ERR_OVR);
		repeat (3 * BIT) @(posedge clock_i);
		chk1(idle, 1'b1);
		end_test("overrun");
	endtask : t_overrun

	task automatic test_done;
		$display("%0d checks, %0d miscompares", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done

	initial begin
		rst_n_i = 1'b0;
		pat = 1'b0;
		flash_data = 8'h00;
		miscompares = 0;
		checked = 0;
		cycles = 0;
		t_sum_erased();
		t_id();
		t_bad_cmd();
		t_sum_pattern();
		t_frame_err();
		t_bad_match();
		t_overrun();
		test_done();
	end
endmodule : tb_top

bind sbr_top sbr_top_asserts i_sbr_top_asserts (.clock_i(clock_i),
	.rst_n_i(rst_n_i), .rxd_i(rxd_i), .txd_o(txd_o),
	.flash_addr_o(flash_addr_o), .flash_rd_o(flash_rd_o),
	.flash_data_i(flash_data_i), .idle_o(idle_o));
